// ==== adc_rx_model.sv ====
// Purpose: Receiver that captures samples on the strobe's rise
// Assumes: Strobe and data are settled levels in the clock domain
// Notes:   Keeps every word, and alternate words in the decimated output
`timescale 1ns/1ps
`default_nettype none
module adc_rx_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire adc_sample_pkg::sample_t sample_bits,
   input wire logic data_valid_strobe,
   output adc_sample_pkg::sample_t cap_word,
   output adc_sample_pkg::sample_t dec_word,
   output var int cap_count
);
   import adc_sample_pkg::*;
   logic prev_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         cap_word <= '0;
         dec_word <= '0;
         cap_count <= 0;
      end else begin
         prev_r <= data_valid_strobe;
         // Capture only on the rise, mid data window
         if (data_valid_strobe && !prev_r) begin
            cap_word <= sample_bits;
            // Low output rates: run the converter faster and keep every other word
            if (!cap_count[0]) begin
               dec_word <= sample_bits;
            end
            cap_count <= cap_count + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== adc_sample_out.sv ====
// Purpose: Sampling and output side of an 11-bit pipelined converter
// Assumes: One 20 MHz clock; conversion clock and pins are asynchronous
// Notes:   Behavioural model; the analog input arrives as a signed code
//
// Functional notes
// - Each conversion clock rise starts a conversion; the code starts none in shutdown or when the buffer is full
// - Eleven output bits, bit 0 least significant
// - Two's complement with the top bit inverted
// - Strobe rising edge marks valid data
// - Strobe is a delayed conversion clock copy
// - Data changes after conversion clock falling edge
// - Level select: open 3.3 V, grounded 2.5 V
// - Common-mode pin high forces low-current shutdown
`timescale 1ns/1ps
`default_nettype none
`include "adc_sample_regs.svh"

// ----------------------------------------------------------------
// Sample buffer
// ----------------------------------------------------------------
module adc_sample_fifo #(
   parameter int WIDTH = `SAMPLE_W,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [`FIFO_LVL_W-1:0] level
);
   import adc_sample_pkg::*;

   localparam int AW = $clog2(DEPTH);

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign level = st_r.wr_ptr_r - st_r.rd_ptr_r;
   assign in_ready = (level != `FIFO_LVL_W'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[st_r.rd_ptr_r[AW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wr_ptr_r = st_r.wr_ptr_r + 1'b1;
      end
      if (pop) begin
         st_nxt.rd_ptr_r = st_r.rd_ptr_r + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Storage has no reset; the pointers guard every read
   always_ff @(posedge clock) begin
      if (push) begin
         mem[st_r.wr_ptr_r[AW-1:0]] <= in_data;
      end
   end
endmodule

// ----------------------------------------------------------------
// Converter output side
// ----------------------------------------------------------------
module adc_sample_out (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic conversion_clock,
   input wire adc_sample_pkg::sample_t analog_input,
   input wire logic output_level_select,
   input wire logic common_mode_ref_high,
   output adc_sample_pkg::sample_t sample_bits,
   output logic data_valid_strobe,
   output logic output_level_3v3,
   output logic bias_enable,
   output logic conversion_stall,
   output logic [`FIFO_LVL_W-1:0] samples_in_flight
);
   import adc_sample_pkg::*;

   top_state_t st_r;
   top_state_t st_nxt;
   logic rise;
   logic fall;
   logic shutdown;
   logic in_ready;
   logic in_valid;
   logic out_valid;
   logic out_ready;
   sample_t head;
   logic [`FIFO_LVL_W-1:0] level;

   assign rise = st_r.clk_s2 & ~st_r.clk_d;
   assign fall = ~st_r.clk_s2 & st_r.clk_d;
   assign shutdown = st_r.cm_s2;
   // A full buffer refuses new conversions rather than losing old ones
   assign in_valid = rise & ~shutdown;
   assign conversion_stall = rise & ~in_ready;
   // Drain only once three later conversions have started
   assign out_ready = fall & ~shutdown & (level > `PIPE_LATENCY);
   assign samples_in_flight = level;

   adc_sample_fifo #(
      .WIDTH(`SAMPLE_W),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(st_r.ain_s2),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .out_data(head),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .level(level)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.clk_s1 = conversion_clock;
      st_nxt.clk_s2 = st_r.clk_s1;
      st_nxt.clk_d = st_r.clk_s2;
      st_nxt.lvl_s1 = output_level_select;
      st_nxt.lvl_s2 = st_r.lvl_s1;
      st_nxt.cm_s1 = common_mode_ref_high;
      st_nxt.cm_s2 = st_r.cm_s1;
      st_nxt.ain_s1 = analog_input;
      st_nxt.ain_s2 = st_r.ain_s1;
      st_nxt.level_3v3_r = st_r.lvl_s2;
      st_nxt.bias_enable_r = ~shutdown;
      // Strobe shares the data register stage so both delays track
      st_nxt.out_r.data_valid_strobe = st_r.clk_s2 & ~shutdown;
      if (out_valid && out_ready) begin
         st_nxt.out_r.sample_bits = {~head[`SAMPLE_MSB], head[`SAMPLE_MSB-1:0]};
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         // Level syncs start at the open-pin level so no false low follows reset
         st_r.lvl_s1 <= `LEVEL_3V3;
         st_r.lvl_s2 <= `LEVEL_3V3;
         st_r.level_3v3_r <= `LEVEL_3V3;
         st_r.bias_enable_r <= `BIAS_ON;
         st_r.out_r.sample_bits <= `SAMPLE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sample_bits = st_r.out_r.sample_bits;
   assign data_valid_strobe = st_r.out_r.data_valid_strobe;
   assign output_level_3v3 = st_r.level_3v3_r;
   assign bias_enable = st_r.bias_enable_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   AST_CONV_START: assert property (
      $rose(st_r.clk_s2) && !shutdown && in_ready |=> level == $past(level) + 1'b1
         || $past(out_ready))
      else $error("conversion rise did not enter the pipeline");
   AST_MSB_INV: assert property (
      out_ready && out_valid |=> sample_bits == {~$past(head[`SAMPLE_MSB]),
         $past(head[`SAMPLE_MSB-1:0])})
      else $error("output coding wrong");
   AST_LSB_ORDER: assert property (
      out_ready && out_valid |=> sample_bits[0] == $past(head[0]))
      else $error("output bit order wrong");
   AST_STROBE_COPY: assert property (
      !$past(shutdown) |-> data_valid_strobe == $past(st_r.clk_s2))
      else $error("strobe is not a delayed clock copy");
   AST_DATA_AT_FALL: assert property (
      $changed(sample_bits) |-> $past(fall))
      else $error("data changed away from falling edge");
   AST_STABLE_AT_STROBE: assert property (
      $rose(data_valid_strobe) |-> $stable(sample_bits))
      else $error("data moved at strobe rise");
   AST_LEVEL_SEL: assert property (
      output_level_3v3 == $past(st_r.lvl_s2))
      else $error("level select not followed");
   AST_SHUTDOWN: assert property (
      shutdown |=> !bias_enable ##0 !data_valid_strobe)
      else $error("shutdown not entered");
   AST_LATENCY: assert property (
      out_ready |-> level >= `PIPE_LATENCY + 1'b1)
      else $error("sample left before its latency");

   COV_SAMPLE_OUT: cover property (out_ready && out_valid);
   COV_FULL: cover property (conversion_stall);
   COV_SHUTDOWN: cover property ($rose(shutdown));
   COV_LEVEL_LOW: cover property (!output_level_3v3);
endmodule
`default_nettype wire

// ==== adc_sample_pkg.sv ====
// Purpose: Types for the converter sample output block
// Assumes: adc_sample_regs.svh holds the numeric constants
// Notes:   Packed structs carry grouped signals
`include "adc_sample_regs.svh"

package adc_sample_pkg;

   typedef logic [`SAMPLE_W-1:0] sample_t;

   // Word that leaves the block on the output pins
   typedef struct packed {
      sample_t sample_bits;
      logic data_valid_strobe;
   } out_word_t;

   // Whole state of the top module
   typedef struct packed {
      logic clk_s1;
      logic clk_s2;
      logic clk_d;
      logic lvl_s1;
      logic lvl_s2;
      logic cm_s1;
      logic cm_s2;
      sample_t ain_s1;
      sample_t ain_s2;
      out_word_t out_r;
      logic level_3v3_r;
      logic bias_enable_r;
   } top_state_t;

   // State of the buffer, pointers carry one wrap bit
   typedef struct packed {
      logic [`FIFO_LVL_W-1:0] wr_ptr_r;
      logic [`FIFO_LVL_W-1:0] rd_ptr_r;
   } fifo_state_t;

endpackage

// ==== adc_sample_regs.svh ====
// Purpose: Constants for the converter sample output block
// Assumes: Included by the package and the design file
// Notes:   Definitions only
`ifndef ADC_SAMPLE_REGS_SVH
`define ADC_SAMPLE_REGS_SVH

// ----------------------------------------------------------------
// Sample format
// ----------------------------------------------------------------
`define SAMPLE_W 11
`define SAMPLE_MSB 10
`define SAMPLE_RST 11'h000

// ----------------------------------------------------------------
// Pipeline and buffering
// ----------------------------------------------------------------
`define PIPE_LATENCY 5'h03
`define FIFO_DEPTH 16
`define FIFO_LVL_W 5

// ----------------------------------------------------------------
// Reset levels of pin-facing outputs
// ----------------------------------------------------------------
`define LEVEL_3V3 1'b1
`define BIAS_ON 1'b1

`endif

// ==== test_adc_sample_out.sv ====
// Purpose: Self-checking bench for the converter output side
// Assumes: Conversion clock phases of 8 system cycles
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "adc_sample_regs.svh"
module test_adc_sample_out;
   import adc_sample_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic conversion_clock = 1'b0;
   logic output_level_select = 1'b1;
   logic common_mode_ref_high = 1'b0;
   logic stall_seen = 1'b0;
   sample_t analog_input = '0;
   sample_t sample_bits, cap_word, dec_word, sb_q;
   logic data_valid_strobe, output_level_3v3, bias_enable, conversion_stall, st_q;
   logic [`FIFO_LVL_W-1:0] samples_in_flight;
   int cap_count;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   sample_t vals [8] = '{11'h000, 11'h3ff, 11'h400, 11'h7ff, 11'h001, 11'h2aa, 11'h555, 11'h7fe};

   adc_sample_out dut (.clock(clock), .rst_n(rst_n), .conversion_clock(conversion_clock),
      .analog_input(analog_input), .output_level_select(output_level_select),
      .common_mode_ref_high(common_mode_ref_high), .sample_bits(sample_bits),
      .data_valid_strobe(data_valid_strobe), .output_level_3v3(output_level_3v3),
      .bias_enable(bias_enable), .conversion_stall(conversion_stall),
      .samples_in_flight(samples_in_flight));
   adc_rx_model rx (.clock(clock), .rst_n(rst_n), .sample_bits(sample_bits),
      .data_valid_strobe(data_valid_strobe), .cap_word(cap_word), .dec_word(dec_word),
      .cap_count(cap_count));

   initial begin
      forever #25 clock = ~clock;
   end

   task automatic complete_run();
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs well under 2000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic check(input logic c, input string m);
      n_tests++;
      if (c !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // Data may only move while the strobe is low
   always @(negedge clock) begin
      if (rst_n && st_q && data_valid_strobe) check(sample_bits === sb_q, "data moved");
      // A refusal stands a whole cycle, so a falling-edge look cannot miss it
      if (rst_n && conversion_stall) stall_seen = 1'b1;
      sb_q = sample_bits;
      st_q = data_valid_strobe;
   end

   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic convert(input sample_t a, input logic s);
      analog_input = a;
      cyc(8);
      // Fixed period for back-to-back calls; any wait between calls stretches the low phase
      conversion_clock = 1'b1;
      cyc(1);
      check(data_valid_strobe === 1'b0, "strobe early");
      cyc(3);
      check(data_valid_strobe === s, "strobe level");
      cyc(4);
      conversion_clock = 1'b0;
   endtask

   task automatic t_stream();
      for (int i = 0; i < 12; i++) begin
         convert(vals[i % 8], 1'b1);
         check(cap_count === i + 1, "capture count");
         check(samples_in_flight === ((i < 3) ? i + 1 : 4), "occupancy");
         if (i >= 4) check(cap_word === (vals[(i - 4) % 8] ^ 11'h400), "word");
         if (i >= 4) check(dec_word === (vals[(i - 4 - (i % 2)) % 8] ^ 11'h400), "decimated");
      end
   endtask

   task automatic t_shut();
      logic [`FIFO_LVL_W-1:0] n;
      common_mode_ref_high = 1'b1;
      cyc(8);
      check(bias_enable === 1'b0, "bias on");
      n = samples_in_flight;
      convert(11'h123, 1'b0);
      convert(11'h321, 1'b0);
      check(samples_in_flight === n, "pushed in shutdown");
      common_mode_ref_high = 1'b0;
      cyc(4);
      check(bias_enable === 1'b1, "bias off");
   endtask

   // Words held over shutdown leave first and in order, then the new ones
   task automatic t_fifo();
      int base;
      base = cap_count;
      for (int j = 0; j < 6; j++) begin
         convert(vals[7 - j], 1'b1);
         check(cap_count === base + j + 1, "capture count after shutdown");
         check(samples_in_flight === 5'h04, "occupancy after shutdown");
         if (j >= 1) check(cap_word === (vals[(j < 4) ? j : 11 - j] ^ 11'h400), "order");
      end
      check(stall_seen === 1'b0, "conversion refused");
   endtask

   initial begin
      cyc(2);
      check(sample_bits === 11'h000 && data_valid_strobe === 1'b0, "reset outputs");
      check(output_level_3v3 === 1'b1 && bias_enable === 1'b1, "reset levels");
      cyc(3);
      rst_n = 1'b1;
      cyc(2);
      t_stream();
      output_level_select = 1'b0;
      cyc(4);
      check(output_level_3v3 === 1'b0, "level low");
      output_level_select = 1'b1;
      cyc(4);
      check(output_level_3v3 === 1'b1, "level high");
      t_shut();
      t_fifo();
      complete_run();
   end
endmodule
`default_nettype wire
